/* ulms_line_modem_status.sv */
// line status, modem status, upper modem control, scratch pad and threshold logic of one channel
// assumes the host port delivers one-cycle read and write strobes, and that the
// receiver and transmitter cores report characters and idle state synchronously
`timescale 1ns/10ps

module ulms_line_modem_status
  import ulms_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   ce,
  // host register port
  input  wire ulms_pkg::ulms_regreq_t regReq,
  output logic [7:0]                  regRdData,
  output logic                        regRdValid,
  // configuration from neighbouring registers
  input  wire logic                   efrEnhanced,
  input  wire logic                   autoCtsEn,
  input  wire logic                   autoRtsEn,
  input  wire logic                   swFlowEn,
  input  wire logic                   fifoMode,
  input  wire logic [7:0]             interruptEnableReg,
  input  wire logic [7:0]             xonChar,
  input  wire logic [7:0]             xoffChar,
  // receiver core
  input  wire logic                   rxDone,
  input  wire ulms_pkg::ulms_rxent_t  rxChar,
  input  wire logic                   rxLineIdle,
  // transmitter core
  input  wire logic                   txStoreEmpty,
  input  wire logic                   txShiftEmpty,
  input  wire logic                   txBitIn,
  input  wire logic                   irPulseIn,
  // serial pins
  input  wire logic                   uartRxIn,
  input  wire logic                   irRxIn,
  output logic                        uartTxOut,
  output logic                        irTxOut,
  output logic                        rxBitOut,
  // modem pins
  input  wire ulms_pkg::ulms_modem_t  modemIn,
  output logic                        dtrN,
  output logic                        rtsN,
  // flow control and events
  output logic                        ctsStop,
  output logic                        flowHold,
  output logic                        xoffReq,
  output logic                        xonReq,
  output logic                        txResume,
  output logic                        modemIntReq,
  output logic                        baudClkEn
);

  // ------
  // state
  // ------
  typedef struct packed {
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] flow_threshold;
    logic [3:0] delta;
    logic [3:0] prevLvl;
    logic       overrun;
    logic       brkSeen;
    logic       flowHold;
    logic       ctsStop;
    logic [7:0] rdData;
    logic       rdValid;
    logic       dtrN;
    logic       rtsN;
    logic       modemInt;
    logic       xoffReq;
    logic       xonReq;
    logic       txResume;
    logic       uartTx;
    logic       irTx;
    logic       rxBit;
  } ulms_state_t;

  ulms_state_t st_ff;
  ulms_state_t nxt_st;

  // ------
  // helpers
  // ------
  function automatic logic [6:0] levelOf(input logic [3:0] nib);
    levelOf = {1'b0, nib, 2'b00};
  endfunction

  function automatic logic hit(input ulms_regreq_t r, input logic [2:0] a);
    hit = (r.addr == a);
  endfunction

  // -----------------------------------------------------------------
  // receive fifo and prescaler
  // -----------------------------------------------------------------
  ulms_rxent_t fifoHead;
  logic [6:0]  fifoCount;
  logic        fifoFull;
  logic        fifoErr;
  logic        fifoPush;
  logic        fifoPop;
  logic        presTick;

  logic        loopOn;
  logic        irdaOn;
  logic        xanyOn;
  logic        tcrSel;
  logic        flowCode;
  logic        brkRepeat;
  logic        auxTwoN;
  logic [3:0]  lvl;
  logic [3:0]  deltaSet;
  logic        msrRead;
  logic        lsrRead;
  logic        ctsHigh;
  logic [7:0]  lsrVal;
  logic [7:0]  msrVal;

  assign loopOn = st_ff.modem_control[MCR_LOOP];
  assign irdaOn = st_ff.modem_control[MCR_IRDA];
  assign xanyOn = st_ff.modem_control[MCR_XANY];
  assign tcrSel = efrEnhanced & st_ff.modem_control[MCR_OUT1];

  // dropped flow codes never reach the fifo
  assign flowCode  = xanyOn & swFlowEn & ((rxChar.data == xonChar) | (rxChar.data == xoffChar));
  assign brkRepeat = rxChar.brk & st_ff.brkSeen;
  assign fifoPush  = rxDone & ~flowCode & ~brkRepeat;
  assign fifoPop   = regReq.rd & hit(regReq, ADDR_RHR);

  ulms_rx_fifo u_rx_fifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .push     (fifoPush),
    .pushEnt  (rxChar),
    .pop      (fifoPop),
    .depthOne (~fifoMode),
    .head     (fifoHead),
    .count    (fifoCount),
    .full     (fifoFull),
    .errAny   (fifoErr)
  );

  ulms_prescaler u_prescaler (
    .clk     (clk),
    .arst_n  (arst_n),
    .ce      (ce),
    .divFour (st_ff.modem_control[MCR_PRESC]),
    .tick    (presTick)
  );

  // -----------------------------------------------------------------
  // modem status levels
  // -----------------------------------------------------------------
  // aux output two is only an internal net, active low
  assign auxTwoN = ~st_ff.modem_control[MCR_AUX2];

  always_comb begin
    if (loopOn) begin
      lvl = {~auxTwoN, st_ff.modem_control[MCR_OUT1], st_ff.modem_control[MCR_DTR], st_ff.modem_control[MCR_RTS]};
    end else begin
      lvl = {~modemIn.cdN, ~modemIn.riN, ~modemIn.dsrN, ~modemIn.ctsN};
    end
  end

  // bit order: 3 cd, 2 ri, 1 dsr, 0 cts
  assign deltaSet[0] = lvl[0] ^ st_ff.prevLvl[0];
  assign deltaSet[1] = lvl[1] ^ st_ff.prevLvl[1];
  assign deltaSet[2] = st_ff.prevLvl[2] & ~lvl[2];
  assign deltaSet[3] = lvl[3] ^ st_ff.prevLvl[3];

  assign msrRead = regReq.rd & hit(regReq, ADDR_MSR) & ~tcrSel;
  assign lsrRead = regReq.rd & hit(regReq, ADDR_LSR);
  assign msrVal  = {lvl, st_ff.delta};

  // clear-to-send high means stop
  assign ctsHigh = ~lvl[0];

  // -----------------------------------------------------------------
  // line status
  // -----------------------------------------------------------------
  always_comb begin
    lsrVal    = 8'h00;
    lsrVal[0] = (fifoCount != 7'h00);
    lsrVal[1] = st_ff.overrun;
    lsrVal[2] = fifoHead.par;
    lsrVal[3] = fifoHead.frm;
    lsrVal[4] = fifoHead.brk;
    lsrVal[5] = txStoreEmpty;
    lsrVal[6] = txStoreEmpty & txShiftEmpty;
    lsrVal[7] = fifoErr;
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // register writes
    if (regReq.wr) begin
      case (regReq.addr)
        ADDR_MCR: begin
          nxt_st.modem_control[4:0]       = regReq.wdata[4:0];
          nxt_st.modem_control[MCR_IRDA]  = regReq.wdata[MCR_IRDA];
          if (efrEnhanced) begin
            nxt_st.modem_control[MCR_XANY]  = regReq.wdata[MCR_XANY];
            nxt_st.modem_control[MCR_PRESC] = regReq.wdata[MCR_PRESC];
          end
        end
        ADDR_MSR: begin
          if (tcrSel) begin
            nxt_st.flow_threshold = regReq.wdata;
          end
        end
        ADDR_SPR: begin
          nxt_st.scratch_pad = regReq.wdata;
        end
        default: begin
          nxt_st.scratch_pad = st_ff.scratch_pad;
        end
      endcase
    end

    // register reads, answered one cycle later
    nxt_st.rdValid = regReq.rd;
    nxt_st.rdData  = 8'h00;
    if (regReq.rd) begin
      case (regReq.addr)
        ADDR_RHR: nxt_st.rdData = fifoHead.data;
        ADDR_MCR: nxt_st.rdData = st_ff.modem_control;
        ADDR_LSR: nxt_st.rdData = lsrVal;
        ADDR_MSR: nxt_st.rdData = tcrSel ? st_ff.flow_threshold : msrVal;
        ADDR_SPR: nxt_st.rdData = st_ff.scratch_pad;
        default:  nxt_st.rdData = 8'h00;
      endcase
    end

    // overrun: a new character always wins over the clearing read
    nxt_st.overrun = (st_ff.overrun & ~lsrRead) | (rxDone & fifoFull & ~flowCode & ~brkRepeat);

    // one break character per break, rearmed when the line idles high
    if (rxLineIdle) begin
      nxt_st.brkSeen = 1'b0;
    end
    if (rxDone & rxChar.brk) begin
      nxt_st.brkSeen = 1'b1;
    end

    // modem deltas, set wins over the clearing read
    nxt_st.prevLvl = lvl;
    nxt_st.delta   = (msrRead ? 4'h0 : st_ff.delta) | deltaSet;
    nxt_st.modemInt = interruptEnableReg[IER_MODEM] & (nxt_st.delta != 4'h0);

    // xon-any: any received character restarts a halted transmitter
    nxt_st.txResume = rxDone & xanyOn;

    // auto clear-to-send: stop only at a character boundary
    if (!autoCtsEn || !ctsHigh) begin
      nxt_st.ctsStop = 1'b0;
    end else if (txShiftEmpty) begin
      nxt_st.ctsStop = 1'b1;
    end

    // receive fifo halt and resume thresholds
    nxt_st.xoffReq = 1'b0;
    nxt_st.xonReq  = 1'b0;
    if (!st_ff.flowHold && (fifoCount >= levelOf(st_ff.flow_threshold[3:0]))) begin
      nxt_st.flowHold = 1'b1;
      nxt_st.xoffReq  = swFlowEn;
    end else if (st_ff.flowHold && (fifoCount <= levelOf(st_ff.flow_threshold[7:4]))) begin
      nxt_st.flowHold = 1'b0;
      nxt_st.xonReq   = swFlowEn;
    end

    // modem outputs go inactive while looped back
    nxt_st.dtrN = loopOn | ~st_ff.modem_control[MCR_DTR];
    nxt_st.rtsN = loopOn | ~st_ff.modem_control[MCR_RTS] | (autoRtsEn & st_ff.flowHold);

    // serial routing
    if (loopOn) begin
      nxt_st.uartTx = 1'b1;
      nxt_st.irTx   = 1'b0;
      nxt_st.rxBit  = irdaOn ? irPulseIn : txBitIn;
    end else if (irdaOn) begin
      nxt_st.uartTx = 1'b1;
      nxt_st.irTx   = irPulseIn;
      nxt_st.rxBit  = irRxIn;
    end else begin
      nxt_st.uartTx = txBitIn;
      nxt_st.irTx   = 1'b0;
      nxt_st.rxBit  = uartRxIn;
    end
  end

  // ------
  // registers
  // ------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff          <= '0;
      st_ff.modem_control      <= MCR_RST;
      st_ff.scratch_pad      <= SPR_RST;
      st_ff.flow_threshold      <= TCR_RST;
      st_ff.dtrN     <= 1'b1;
      st_ff.rtsN     <= 1'b1;
      st_ff.uartTx   <= 1'b1;
      st_ff.rxBit    <= 1'b1;
      st_ff.prevLvl  <= 4'h0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ------
  // outputs
  // ------
  assign regRdData   = st_ff.rdData;
  assign regRdValid  = st_ff.rdValid;
  assign uartTxOut   = st_ff.uartTx;
  assign irTxOut     = st_ff.irTx;
  assign rxBitOut    = st_ff.rxBit;
  assign dtrN        = st_ff.dtrN;
  assign rtsN        = st_ff.rtsN;
  assign ctsStop     = st_ff.ctsStop;
  assign flowHold    = st_ff.flowHold;
  assign xoffReq     = st_ff.xoffReq;
  assign xonReq      = st_ff.xonReq;
  assign txResume    = st_ff.txResume;
  assign modemIntReq = st_ff.modemInt;
  assign baudClkEn   = presTick;

endmodule

/* ulms_line_modem_status_checker.sv */
// assertions on the ports of the line and modem status block
// assumes binding into ulms_line_modem_status
`timescale 1ns/10ps

module ulms_lms_checker
  import ulms_pkg::*;
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  ce,
  // host port and config
  input wire ulms_pkg::ulms_regreq_t regReq,
  input wire logic [7:0]            regRdData,
  input wire logic                  efrEnhanced,
  input wire logic [7:0]            interruptEnableReg,
  // pins and events
  input wire ulms_pkg::ulms_modem_t modemIn,
  input wire logic                  dtrN,
  input wire logic                  rtsN,
  input wire logic                  irTxOut,
  input wire logic                  modemIntReq,
  input wire logic                  baudClkEn
);
  import ulms_pkg::*;
  logic [7:0] mcrSh_ff;
  // shadow of modem control, gated bits kept
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mcrSh_ff <= 8'h00;
    end else if (ce && regReq.wr && regReq.addr == ADDR_MCR) begin
      mcrSh_ff <= efrEnhanced ? regReq.wdata : {mcrSh_ff[7], regReq.wdata[6], mcrSh_ff[5], regReq.wdata[4:0]};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || !ce);

  sequence msrRead;
    regReq.rd && regReq.addr == ADDR_MSR && !(efrEnhanced && mcrSh_ff[MCR_OUT1]);
  endsequence

  chk_msr_normal: assert property (msrRead ##0 !mcrSh_ff[MCR_LOOP] |=>
    regRdData[7:4] == ~{$past(modemIn.cdN), $past(modemIn.riN), $past(modemIn.dsrN), $past(modemIn.ctsN)})
    else $error("modem level bits differ from pins");
  chk_msr_loop: assert property (msrRead ##0 mcrSh_ff[MCR_LOOP] |=>
    regRdData[7:4] == {$past(mcrSh_ff[3:2]), $past(mcrSh_ff[0]), $past(mcrSh_ff[1])})
    else $error("loop status differs from modem control");
  chk_loop_quiet: assert property (mcrSh_ff[MCR_LOOP] && $past(mcrSh_ff[MCR_LOOP]) |-> dtrN && rtsN)
    else $error("modem outputs active in loopback");
  chk_dtr_level: assert property (!mcrSh_ff[MCR_LOOP] && $stable(mcrSh_ff) |-> dtrN == !mcrSh_ff[MCR_DTR])
    else $error("terminal ready pin wrong");
  chk_ir_idle: assert property (!mcrSh_ff[MCR_IRDA] && !$past(mcrSh_ff[MCR_IRDA]) |-> !irTxOut)
    else $error("infrared output not idle low");
  chk_baud_full: assert property ($past(arst_n) && !mcrSh_ff[MCR_PRESC]
    && !$past(mcrSh_ff[MCR_PRESC]) |-> baudClkEn)
    else $error("undivided baud enable missing");
  chk_baud_gap: assert property (!baudClkEn [*4] |-> 1'b0)
    else $error("baud enable gap above four");
  chk_baud_quarter: assert property (baudClkEn && mcrSh_ff[7] && $past(mcrSh_ff[7])
    && !(regReq.wr && regReq.addr == ADDR_MCR) |=> !baudClkEn [*2])
    else $error("divided baud enable too frequent");
  chk_int_off: assert property (!interruptEnableReg[IER_MODEM] |=> !modemIntReq)
    else $error("modem interrupt while disabled");
  chk_int_on: assert property (interruptEnableReg[IER_MODEM] && !mcrSh_ff[MCR_LOOP]
    && ($changed({modemIn.ctsN, modemIn.dsrN, modemIn.cdN}) || $rose(modemIn.riN)) |-> ##[1:2] modemIntReq)
    else $error("modem interrupt missing after change");
endmodule

bind ulms_line_modem_status ulms_lms_checker u_chk (
  .clk(clk), .arst_n(arst_n), .ce(ce), .regReq(regReq), .regRdData(regRdData),
  .efrEnhanced(efrEnhanced), .interruptEnableReg(interruptEnableReg), .modemIn(modemIn),
  .dtrN(dtrN), .rtsN(rtsN), .irTxOut(irTxOut), .modemIntReq(modemIntReq), .baudClkEn(baudClkEn)
);

/* ulms_modem_model.sv */
// remote modem: drives the modem status pins and the receive lines
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/10ps

module ulms_modem_model
  import ulms_pkg::*;
(
  // clock
  input  wire logic             clk,
  // lines toward the channel
  output ulms_pkg::ulms_modem_t modemIn,
  output logic                  uartRxIn,
  output logic                  irRxIn
);
  import ulms_pkg::*;
  ulms_modem_t lvl;
  initial begin
    lvl = 4'hF;
  end
  // pulled-up pins idle inactive, rx idles at mark
  assign modemIn  = lvl;
  assign uartRxIn = 1'b1;
  assign irRxIn   = 1'b0;

  // answer after some idle cycles
  task automatic drive(input logic [3:0] v, input int slow);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    #1;
    lvl = v;
  endtask

  // high holds off the local transmitter
  task automatic stop_tx(input logic halt);
    drive({halt, lvl.dsrN, lvl.riN, lvl.cdN}, 0);
  endtask
endmodule

/* ulms_pkg.sv */
// constants, field layouts and carrier types of the uart line and modem status block
// assumes one 200 MHz clock and a byte-wide register port from the serial host interface
//
// Contract
// - aux output two drives internal loop signal
// - loopback bit selects local loopback mode
// - xon-any resumes transmitter; enhanced-only write
// - xon-any stores chars except flow codes
// - infrared bit routes serial paths, idle low
// - prescaler divides clock by four, enhanced-only
// - data ready while any character held
// - overrun on full fifo, char dropped
// - parity tag belongs to head character
// - framing tag belongs to head character
// - break flagged, one break char stored
// - holding empty follows transmit store
// - transmitter idle when store and shifter empty
// - fifo error summary while tagged entry remains
// - modem deltas set on change, interrupt
// - ring delta only on ringing end
// - auto clear-to-send halts after current char
// - status levels are complemented pins normally
// - loopback status mirrors modem control bits
// - scratch pad keeps value, resets to FF
// - threshold register replaces status when selected
// - halt level is low nibble times four
// - resume level is high nibble times four

package ulms_pkg;

  // ------
  // register offsets
  // ------
  localparam logic [2:0] ADDR_RHR = 3'h0;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SPR = 3'h7;

  // ------
  // reset values
  // ------
  localparam logic [7:0] MCR_RST  = 8'h00;
  localparam logic [7:0] SPR_RST  = 8'hFF;
  localparam logic [7:0] TCR_RST  = 8'h00;

  // ------
  // modem control and interrupt enable bit positions
  // ------
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_OUT1  = 2;
  localparam int MCR_AUX2  = 3;
  localparam int MCR_LOOP  = 4;
  localparam int MCR_XANY  = 5;
  localparam int MCR_IRDA  = 6;
  localparam int MCR_PRESC = 7;
  localparam int IER_MODEM = 3;

  // ------
  // fifo and prescaler sizes
  // ------
  localparam int         FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_FULL  = 7'h40;
  localparam logic [1:0] PRESC_LAST = 2'h3;

  // ------
  // carriers
  // ------
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ulms_rxent_t;

  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ulms_regreq_t;

  typedef struct packed {
    logic ctsN;
    logic dsrN;
    logic riN;
    logic cdN;
  } ulms_modem_t;

endpackage

/* ulms_prescaler.sv */
// clock prescaler: emits a baud-generator enable every clock or every fourth clock
// assumes the caller gates it with the block clock enable
`timescale 1ns/10ps

module ulms_prescaler
  import ulms_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // control and result
  input  wire logic divFour,
  output logic      tick
);

  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } ulms_presc_t;

  ulms_presc_t st_ff;
  ulms_presc_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (divFour) begin
      nxt_st.cnt  = (st_ff.cnt == PRESC_LAST) ? 2'h0 : st_ff.cnt + 2'h1;
      nxt_st.tick = (st_ff.cnt == PRESC_LAST);
    end else begin
      nxt_st.cnt  = 2'h0;
      nxt_st.tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule

/* ulms_rx_fifo.sv */
// receive fifo of characters with their error tags, flip-flop storage
// assumes push and pop are one-cycle strobes, pop only while not empty
`timescale 1ns/10ps

module ulms_rx_fifo
  import ulms_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               ce,
  // fill and drain
  input  wire logic               push,
  input  wire ulms_pkg::ulms_rxent_t pushEnt,
  input  wire logic               pop,
  input  wire logic               depthOne,
  // state
  output ulms_pkg::ulms_rxent_t   head,
  output logic [6:0]              count,
  output logic                    full,
  output logic                    errAny
);

  typedef struct packed {
    ulms_rxent_t [FIFO_DEPTH-1:0] mem;
    logic [5:0]                   wrIdx;
    logic [5:0]                   rdIdx;
    logic [6:0]                   cnt;
    logic [6:0]                   errCnt;
  } ulms_fifo_t;

  ulms_fifo_t st_ff;
  ulms_fifo_t nxt_st;
  logic       doPush;
  logic       doPop;
  logic       pushErr;
  logic       popErr;

  function automatic logic hasErr(input ulms_rxent_t e);
    hasErr = e.brk | e.frm | e.par;
  endfunction

  assign full    = depthOne ? (st_ff.cnt != 7'h00) : (st_ff.cnt == FIFO_FULL);
  assign doPush  = push & ~full;
  assign doPop   = pop & (st_ff.cnt != 7'h00);
  assign pushErr = doPush & hasErr(pushEnt);
  assign popErr  = doPop & hasErr(st_ff.mem[st_ff.rdIdx]);

  always_comb begin
    nxt_st = st_ff;
    if (doPush) begin
      nxt_st.mem[st_ff.wrIdx] = pushEnt;
      nxt_st.wrIdx            = st_ff.wrIdx + 6'h01;
    end
    if (doPop) begin
      nxt_st.rdIdx = st_ff.rdIdx + 6'h01;
    end
    nxt_st.cnt    = st_ff.cnt + {6'h00, doPush} - {6'h00, doPop};
    nxt_st.errCnt = st_ff.errCnt + {6'h00, pushErr} - {6'h00, popErr};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign head   = (st_ff.cnt != 7'h00) ? st_ff.mem[st_ff.rdIdx] : '0;
  assign count  = st_ff.cnt;
  assign errAny = (st_ff.errCnt != 7'h00);

endmodule

/* ulms_tb.sv */
// self-checking bench of the line and modem status block
// assumes the modem model and the bound checker
`timescale 1ns/10ps

module tb;
  import ulms_pkg::*;
  logic clk, arst_n, ce, efrEnhanced, autoCtsEn, autoRtsEn, swFlowEn, fifoMode;
  logic rxDone, rxLineIdle, txStoreEmpty, txShiftEmpty, txBitIn, irPulseIn, uartRxIn, irRxIn;
  logic regRdValid, uartTxOut, irTxOut, rxBitOut, dtrN, rtsN, ctsStop, flowHold;
  logic xoffReq, xonReq, txResume, modemIntReq, baudClkEn, seenRes;
  logic [7:0] interruptEnableReg, xonChar, xoffChar, regRdData, rdv;
  ulms_regreq_t regReq;
  ulms_rxent_t  rxChar;
  ulms_modem_t  modemIn;
  int n_errors, compares;

  ulms_line_modem_status DUT (
    .clk(clk), .arst_n(arst_n), .ce(ce), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
    .efrEnhanced(efrEnhanced), .autoCtsEn(autoCtsEn), .autoRtsEn(autoRtsEn), .swFlowEn(swFlowEn),
    .fifoMode(fifoMode), .interruptEnableReg(interruptEnableReg), .xonChar(xonChar), .xoffChar(xoffChar),
    .rxDone(rxDone), .rxChar(rxChar), .rxLineIdle(rxLineIdle), .txStoreEmpty(txStoreEmpty),
    .txShiftEmpty(txShiftEmpty), .txBitIn(txBitIn), .irPulseIn(irPulseIn), .uartRxIn(uartRxIn),
    .irRxIn(irRxIn), .uartTxOut(uartTxOut), .irTxOut(irTxOut), .rxBitOut(rxBitOut), .modemIn(modemIn),
    .dtrN(dtrN), .rtsN(rtsN), .ctsStop(ctsStop), .flowHold(flowHold), .xoffReq(xoffReq), .xonReq(xonReq),
    .txResume(txResume), .modemIntReq(modemIntReq), .baudClkEn(baudClkEn)
  );
  ulms_modem_model m (.clk(clk), .modemIn(modemIn), .uartRxIn(uartRxIn), .irRxIn(irRxIn));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ------
  // shared tasks
  // ------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regReq = '{a, 1'b1, 1'b0, d};
    tick(1);
    regReq.wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [2:0] a);
    regReq = '{a, 1'b0, 1'b1, 8'h00};
    tick(1);
    regReq.rd = 1'b0;
    check({7'h00, regRdValid}, 8'h01);
    rdv = regRdData;
    tick(1);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    check(rdv, e);
  endtask
  task automatic push(input ulms_rxent_t c);
    rxChar = c;
    rxDone = 1'b1;
    tick(1);
    rxDone = 1'b0;
    seenRes = txResume;
    tick(1);
    seenRes |= txResume;
  endtask
  task automatic cnt_baud(input logic [7:0] e);
    logic [7:0] cnt;
    cnt = 8'h00;
    for (int i = 0; i < 16; i++) begin
      cnt += {7'h00, baudClkEn};
      tick(1);
    end
    check(cnt, e);
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_regs;
    rdc(ADDR_MCR, MCR_RST);
    rdc(ADDR_SPR, SPR_RST);
    rdc(ADDR_LSR, 8'h60);
    rdc(ADDR_MSR, 8'h00);
    wr(ADDR_SPR, 8'h5A);
    wr(3'h1, 8'hA5);
    rdc(3'h1, 8'h00);
    rdc(ADDR_SPR, 8'h5A);
    wr(ADDR_MCR, 8'hA0);
    rdc(ADDR_MCR, 8'h00);
    efrEnhanced = 1'b1;
    wr(ADDR_MCR, 8'hA0);
    rdc(ADDR_MCR, 8'hA0);
    cnt_baud(8'h04);
    wr(ADDR_MCR, 8'h00);
    cnt_baud(8'h10);
  endtask
  task automatic t_loop;
    efrEnhanced = 1'b0;
    wr(ADDR_MCR, 8'h1F);
    rd(ADDR_MSR);
    rdc(ADDR_MSR, 8'hF0);
    check({7'h00, dtrN}, 8'h01);
    wr(ADDR_MCR, 8'h17);
    rd(ADDR_MSR);
    rdc(ADDR_MSR, 8'h70);
    wr(ADDR_MCR, 8'h00);
    rd(ADDR_MSR);
  endtask
  task automatic t_modem;
    interruptEnableReg = 8'h08;
    m.drive(4'h7, 0);
    tick(2);
    check({7'h00, modemIntReq}, 8'h01);
    rdc(ADDR_MSR, 8'h11);
    rdc(ADDR_MSR, 8'h10);
    check({7'h00, modemIntReq}, 8'h00);
    m.drive(4'h5, 2);
    tick(2);
    rdc(ADDR_MSR, 8'h50);
    m.drive(4'h7, 0);
    tick(2);
    rdc(ADDR_MSR, 8'h14);
    m.drive(4'h2, 0);
    tick(2);
    rdc(ADDR_MSR, 8'hBA);
    interruptEnableReg = 8'h00;
    m.drive(4'hF, 0);
    tick(2);
    rdc(ADDR_MSR, 8'h0B);
  endtask
  task automatic t_rx;
    fifoMode = 1'b0;
    push('{1'b0, 1'b0, 1'b1, 8'h31});
    rdc(ADDR_LSR, 8'hE5);
    push('{1'b0, 1'b0, 1'b0, 8'h32});
    rdc(ADDR_LSR, 8'hE7);
    rdc(ADDR_RHR, 8'h31);
    rdc(ADDR_LSR, 8'h60);
    fifoMode = 1'b1;
    push('{1'b0, 1'b0, 1'b0, 8'h41});
    push('{1'b0, 1'b1, 1'b0, 8'h42});
    rdc(ADDR_LSR, 8'hE1);
    rdc(ADDR_RHR, 8'h41);
    rdc(ADDR_LSR, 8'hE9);
    rdc(ADDR_RHR, 8'h42);
    rxLineIdle = 1'b0;
    push('{1'b1, 1'b0, 1'b0, 8'h00});
    push('{1'b1, 1'b0, 1'b0, 8'h00});
    rxLineIdle = 1'b1;
    rdc(ADDR_LSR, 8'hF1);
    rdc(ADDR_RHR, 8'h00);
    rdc(ADDR_LSR, 8'h60);
    txStoreEmpty = 1'b0;
    txShiftEmpty = 1'b0;
    tick(1);
    rdc(ADDR_LSR, 8'h00);
    txStoreEmpty = 1'b1;
    tick(1);
    rdc(ADDR_LSR, 8'h20);
    txShiftEmpty = 1'b1;
  endtask
  task automatic t_flow;
    efrEnhanced = 1'b1;
    swFlowEn = 1'b1;
    wr(ADDR_MCR, 8'h20);
    push('{1'b0, 1'b0, 1'b0, 8'h11});
    check({7'h00, seenRes}, 8'h01);
    push('{1'b0, 1'b0, 1'b0, 8'h13});
    rdc(ADDR_LSR, 8'h60);
    push('{1'b0, 1'b0, 1'b0, 8'h55});
    rdc(ADDR_RHR, 8'h55);
    wr(ADDR_MCR, 8'h04);
    push('{1'b0, 1'b0, 1'b0, 8'h56});
    check({7'h00, seenRes}, 8'h00);
    rd(ADDR_RHR);
    wr(ADDR_MSR, 8'h12);
    rdc(ADDR_MSR, 8'h12);
    for (int i = 0; i < 7; i++) begin
      push('{1'b0, 1'b0, 1'b0, 8'h60});
    end
    check({7'h00, flowHold}, 8'h00);
    push('{1'b0, 1'b0, 1'b0, 8'h61});
    check({7'h00, flowHold}, 8'h01);
    check(8'(xoffReq), 8'h01);
    for (int i = 0; i < 8; i++) begin
      rd(ADDR_RHR);
      check(8'(xonReq), 8'(i == 3));
      tick(1);
      check({7'h00, flowHold}, {7'h00, i < 3});
    end
    efrEnhanced = 1'b0;
    wr(ADDR_MSR, 8'h34);
    efrEnhanced = 1'b1;
    rdc(ADDR_MSR, 8'h12);
    wr(ADDR_MCR, 8'h00);
    rdc(ADDR_MSR, 8'h00);
  endtask
  task automatic t_pins;
    txBitIn = 1'b0;
    wr(ADDR_MCR, 8'h10);
    check({7'h00, rxBitOut}, 8'h00);
    check({7'h00, uartTxOut}, 8'h01);
    wr(ADDR_MCR, 8'h40);
    irPulseIn = 1'b1;
    tick(2);
    check({7'h00, irTxOut}, 8'h01);
    irPulseIn = 1'b0;
    wr(ADDR_MCR, 8'h00);
    check({7'h00, uartTxOut}, 8'h00);
    check({7'h00, rxBitOut}, 8'h01);
    autoCtsEn = 1'b1;
    txShiftEmpty = 1'b0;
    m.stop_tx(1'b1);
    tick(3);
    check({7'h00, ctsStop}, 8'h00);
    txShiftEmpty = 1'b1;
    tick(2);
    check({7'h00, ctsStop}, 8'h01);
    m.stop_tx(1'b0);
    tick(2);
    check({7'h00, ctsStop}, 8'h00);
  endtask

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up;
  end

  initial begin
    {arst_n, efrEnhanced, autoCtsEn, autoRtsEn, swFlowEn, rxDone, irPulseIn} = 7'h00;
    {ce, fifoMode, rxLineIdle, txStoreEmpty, txShiftEmpty, txBitIn} = 6'h3F;
    interruptEnableReg = 8'h00;
    xonChar = 8'h11;
    xoffChar = 8'h13;
    regReq = '0;
    rxChar = '0;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_regs;
    t_loop;
    t_modem;
    t_rx;
    t_flow;
    t_pins;
    wrap_up;
  end
endmodule
